// *** design/alpm_ctrl.sv ***
// Power-mode controller for the converter: normal, nap during acquisition, deep power-down.
// Assumes register writes arrive already decoded on mclk; conversion trigger and
// chip select are raw pins and are synchronised here.
// Function
// R01: Normal mode keeps all circuits powered
// R02: Two selectable low-power modes: nap, powerdown
// R03: Nap powers down acquisition blocks
// R04: Host sets nap enable, holds trigger high
// R05: Nap entered at conversion end, trigger high
// R06: Trigger fall wakes; host waits wake time
// R07: Nap enable bit active when one
// R08: Conversion time fixed; only nap stretches
// R09: Host unlocks control register before powerdown
// R10: Powerdown entered on chip-select rising edge
// R11: Powerdown switches off all analog blocks
// R12: Registers and interface survive powerdown
// R13: Host clears request bit to exit
// R14: Ready pin rises once exit begins
// R15: Host waits exit time before converting
// R16: Request without unlock is ignored
module alpm_ctrl #(
    parameter int PWRUP_CYCLES = alpm_pkg::PWRUP_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Pins
    input wire logic convTrigPin,
    input wire logic chipSelNPin,
    // Register writes from serial front end
    input wire alpm_pkg::alpm_wr_t regWr,
    // Status
    output logic readyInd,
    output logic deepPowerdownMode,
    output logic napMode,
    output logic convBusy,
    output alpm_pkg::alpm_pwr_t pwrEn,
    output logic [7:0] powerControlReg
);

    // Pin synchronisers
    logic [1:0] trigSync_ff, nxt_trigSync;
    logic [1:0] csSync_ff, nxt_csSync;
    logic trigD_ff, nxt_trigD;
    logic csD_ff, nxt_csD;
    logic trigS, csS, trigRise, trigFall, csRise;

    always_comb begin
        nxt_trigSync = {trigSync_ff[0], convTrigPin};
        nxt_csSync = {csSync_ff[0], chipSelNPin};
        trigS = trigSync_ff[1];
        csS = csSync_ff[1];
        nxt_trigD = trigS;
        nxt_csD = csS;
        trigRise = trigS && !trigD_ff;
        trigFall = !trigS && trigD_ff;
        csRise = csS && !csD_ff;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            trigSync_ff <= 2'h0;
            csSync_ff <= 2'h3;
            trigD_ff <= 1'b0;
            csD_ff <= 1'b1;
        end else begin
            trigSync_ff <= nxt_trigSync;
            csSync_ff <= nxt_csSync;
            trigD_ff <= nxt_trigD;
            csD_ff <= nxt_csD;
        end
    end

    // Register file: unlock and power control
    logic [7:0] pwrCtrl_ff, nxt_pwrCtrl;
    logic unlocked_ff, nxt_unlocked;
    logic pdPending_ff, nxt_pdPending;
    logic pd_ff, nxt_pd;
    logic exitStart_ff, nxt_exitStart;

    always_comb begin
        nxt_pwrCtrl = pwrCtrl_ff;
        nxt_unlocked = unlocked_ff;
        nxt_pdPending = pdPending_ff;
        nxt_pd = pd_ff;
        nxt_exitStart = 1'b0;
        if (regWr.valid) begin
            // Registers stay writable in every mode; see R12
            if (regWr.addr == alpm_pkg::UNLOCK_ADDR) begin
                nxt_unlocked = (regWr.data == alpm_pkg::UNLOCK_KEY); // see R09
            end else if (regWr.addr == alpm_pkg::PWR_CTRL_ADDR) begin
                nxt_pwrCtrl[alpm_pkg::NAP_EN_BIT] = regWr.data[alpm_pkg::NAP_EN_BIT]; // see R02
                if (regWr.data[alpm_pkg::DEEP_POWERDOWN_REQUEST_BIT]) begin
                    // Setting needs the unlock; locked write leaves bit alone, see R16
                    if (unlocked_ff) begin
                        nxt_pwrCtrl[alpm_pkg::DEEP_POWERDOWN_REQUEST_BIT] = 1'b1;
                        nxt_pdPending = 1'b1; // see R10
                        nxt_unlocked = 1'b0;
                    end
                end else begin
                    // Clearing the request starts the exit; see R13
                    if (pwrCtrl_ff[alpm_pkg::DEEP_POWERDOWN_REQUEST_BIT] || pd_ff) begin
                        nxt_exitStart = pd_ff;
                    end
                    nxt_pwrCtrl[alpm_pkg::DEEP_POWERDOWN_REQUEST_BIT] = 1'b0;
                    nxt_pdPending = 1'b0;
                    nxt_pd = 1'b0;
                end
            end
        end
        // Entry on the chip-select rising edge after the request
        if (pdPending_ff && csRise && !(regWr.valid && regWr.addr == alpm_pkg::PWR_CTRL_ADDR)) begin
            nxt_pd = 1'b1; // see R10
            nxt_pdPending = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pwrCtrl_ff <= alpm_pkg::PWR_CTRL_RST;
            unlocked_ff <= 1'b0;
            pdPending_ff <= 1'b0;
            pd_ff <= 1'b0;
            exitStart_ff <= 1'b0;
        end else begin
            pwrCtrl_ff <= nxt_pwrCtrl;
            unlocked_ff <= nxt_unlocked;
            pdPending_ff <= nxt_pdPending;
            pd_ff <= nxt_pd;
            exitStart_ff <= nxt_exitStart;
        end
    end

    // Power-up timer after deep power-down
    logic [15:0] pwrupCnt_ff, nxt_pwrupCnt;
    logic rdy_ff, nxt_rdy;

    always_comb begin
        nxt_pwrupCnt = pwrupCnt_ff;
        nxt_rdy = rdy_ff;
        if (pd_ff) begin
            nxt_rdy = 1'b0;
            nxt_pwrupCnt = 16'h0;
        end else if (exitStart_ff) begin
            // Ready rises as soon as the clear is processed; see R14
            nxt_rdy = 1'b1;
            nxt_pwrupCnt = 16'(PWRUP_CYCLES);
        end else if (pwrupCnt_ff != 16'h0) begin
            nxt_pwrupCnt = pwrupCnt_ff - 16'h1;
        end else begin
            nxt_rdy = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pwrupCnt_ff <= 16'h0;
            rdy_ff <= 1'b0;
        end else begin
            pwrupCnt_ff <= nxt_pwrupCnt;
            rdy_ff <= nxt_rdy;
        end
    end

    // Conversion and nap sequencing
    alpm_pkg::alpm_conv_state_t st_ff, nxt_st;
    logic [15:0] cnt_ff, nxt_cnt;
    logic napEn;

    always_comb begin
        napEn = pwrCtrl_ff[alpm_pkg::NAP_EN_BIT] == 1'b1; // see R07
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        unique case (st_ff)
            alpm_pkg::ALPM_NORMAL: begin
                // Trigger ignored while powered down or still powering up
                if (trigRise && !pd_ff && pwrupCnt_ff == 16'h0) begin
                    nxt_st = alpm_pkg::ALPM_CONV;
                    nxt_cnt = 16'(alpm_pkg::CONV_CYC); // see R08
                end
            end
            alpm_pkg::ALPM_CONV: begin
                if (cnt_ff > 16'h1) begin
                    nxt_cnt = cnt_ff - 16'h1;
                end else begin
                    nxt_cnt = 16'h0;
                    // Nap only with enable set and trigger still high; see R05
                    nxt_st = (napEn && trigS) ? alpm_pkg::ALPM_NAP : alpm_pkg::ALPM_NORMAL;
                end
            end
            alpm_pkg::ALPM_NAP: begin
                if (trigFall) begin
                    nxt_st = alpm_pkg::ALPM_WAKE; // see R06
                    nxt_cnt = 16'(alpm_pkg::NAP_WAKE_CYC);
                end
            end
            alpm_pkg::ALPM_WAKE: begin
                if (cnt_ff > 16'h1) begin
                    nxt_cnt = cnt_ff - 16'h1;
                end else begin
                    nxt_cnt = 16'h0;
                    nxt_st = alpm_pkg::ALPM_NORMAL;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= alpm_pkg::ALPM_NORMAL;
            cnt_ff <= 16'h0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // Outputs
    logic napOut_ff, busyOut_ff;
    alpm_pkg::alpm_pwr_t pwr_ff, nxt_pwr;

    always_comb begin
        nxt_pwr = '{acqBlocksOn: 1'b1, convBlocksOn: 1'b1, refBufOn: 1'b1}; // see R01
        if (nxt_pd) begin
            nxt_pwr = '{acqBlocksOn: 1'b0, convBlocksOn: 1'b0, refBufOn: 1'b0}; // see R11
        end else if (nxt_st == alpm_pkg::ALPM_NAP) begin
            nxt_pwr.acqBlocksOn = 1'b0; // see R03
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pwr_ff <= '{acqBlocksOn: 1'b1, convBlocksOn: 1'b1, refBufOn: 1'b1};
            napOut_ff <= 1'b0;
            busyOut_ff <= 1'b0;
        end else begin
            pwr_ff <= nxt_pwr;
            napOut_ff <= (nxt_st == alpm_pkg::ALPM_NAP);
            busyOut_ff <= (nxt_st == alpm_pkg::ALPM_CONV);
        end
    end

    assign pwrEn = pwr_ff;
    assign napMode = napOut_ff;
    assign convBusy = busyOut_ff;
    assign readyInd = rdy_ff;
    assign deepPowerdownMode = pd_ff;
    assign powerControlReg = pwrCtrl_ff;

    // Run length of each conversion; a counter, as the span is too long to unroll
    logic [15:0] busyLen_ff, nxt_busyLen;

    always_comb begin
        nxt_busyLen = convBusy ? busyLen_ff + 16'h1 : 16'h0;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busyLen_ff <= 16'h0;
        end else begin
            busyLen_ff <= nxt_busyLen;
        end
    end

    // Assertions
    a_pd_analog_off: assert property (@(posedge mclk) disable iff (rst)
        deepPowerdownMode |-> !pwrEn.acqBlocksOn && !pwrEn.convBlocksOn && !pwrEn.refBufOn) // see R11
        else $error("Analog block on in powerdown");
    a_normal_all_on: assert property (@(posedge mclk) disable iff (rst)
        (!deepPowerdownMode && !napMode) |-> pwrEn.acqBlocksOn && pwrEn.convBlocksOn) // see R01
        else $error("Block off in normal mode");
    a_pd_entry_cs: assert property (@(posedge mclk) disable iff (rst)
        $rose(pd_ff) |-> $past(csRise)) // see R10
        else $error("Powerdown entered without chip select edge");
    a_locked_ignored: assert property (@(posedge mclk) disable iff (rst)
        (regWr.valid && regWr.addr == alpm_pkg::PWR_CTRL_ADDR && regWr.data[0] && !unlocked_ff
         && !powerControlReg[0]) |=> !powerControlReg[0]) // see R16
        else $error("Locked powerdown request accepted");
    a_ready_on_exit: assert property (@(posedge mclk) disable iff (rst)
        $fell(pd_ff) |=> readyInd) // see R14
        else $error("Ready not raised on exit");
    a_conv_fixed: assert property (@(posedge mclk) disable iff (rst)
        $fell(convBusy) |-> busyLen_ff == 16'(alpm_pkg::CONV_CYC)) // see R08
        else $error("Conversion time not fixed");
    a_nap_entry: assert property (@(posedge mclk) disable iff (rst)
        $rose(napMode) |-> $past(napEn) && $past(trigS)) // see R05
        else $error("Nap without enable or trigger");
    a_nap_wake: assert property (@(posedge mclk) disable iff (rst)
        (napMode && trigFall) |=> !napMode ##[1:25] st_ff == alpm_pkg::ALPM_NORMAL) // see R06
        else $error("Nap wake not timely");
    a_nap_acq_off: assert property (@(posedge mclk) disable iff (rst)
        (napMode && !deepPowerdownMode) |-> !pwrEn.acqBlocksOn && pwrEn.convBlocksOn) // see R03
        else $error("Nap power pattern wrong");
    a_pd_not_ready: assert property (@(posedge mclk) disable iff (rst)
        deepPowerdownMode |=> !readyInd) // see R14
        else $error("Ready high in powerdown");
    a_pd_no_conv: assert property (@(posedge mclk) disable iff (rst)
        (deepPowerdownMode && !convBusy) |=> !convBusy) // see R11
        else $error("Conversion started in powerdown");
    a_pwrup_no_conv: assert property (@(posedge mclk) disable iff (rst)
        (pwrupCnt_ff != 16'h0 && !convBusy) |=> !convBusy) // see R15
        else $error("Conversion started during power-up");

endmodule : alpm_ctrl

// *** design/alpm_pkg.sv ***
// Package for the converter power-mode controller: modes, register layout, timing.
// Assumes a 200 MHz mclk; all timing counts are derived here from times in ns.
package alpm_pkg;

    // Conversion and nap sequencing states
    typedef enum logic [1:0] {
        ALPM_NORMAL = 2'h0,
        ALPM_CONV = 2'h1,
        ALPM_NAP = 2'h2,
        ALPM_WAKE = 2'h3
    } alpm_conv_state_t;

    // Register addresses and values reached over the serial interface
    localparam logic [7:0] UNLOCK_ADDR = 8'h11;
    localparam logic [7:0] UNLOCK_KEY = 8'h69;
    localparam logic [7:0] PWR_CTRL_ADDR = 8'h10;
    localparam int NAP_EN_BIT = 1;
    localparam int DEEP_POWERDOWN_REQUEST_BIT = 0;
    localparam logic [7:0] PWR_CTRL_RST = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int CONV_TIME_NS = 300;
    localparam int NAP_WAKE_NS = 100;
    localparam int PWRUP_NS = 1000;
    localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NAP_WAKE_CYC = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_CYC = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register write from the serial front end
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } alpm_wr_t;

    // Analog power enables
    typedef struct packed {
        logic acqBlocksOn;
        logic convBlocksOn;
        logic refBufOn;
    } alpm_pwr_t;

endpackage : alpm_pkg

// *** verif/alpm_host.sv ***
// Host-side model: drives conversion trigger, chip select and decoded register writes.
// Assumes mclk from the bench; every change lands by non-blocking assignment at posedge.
module alpm_host (
    // Clock
    input wire logic mclk,
    // Pins and writes toward the block
    output logic convTrig,
    output logic chipSelN,
    output alpm_pkg::alpm_wr_t regWr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        convTrig = 1'h0;
        chipSelN = 1'h1;
        regWr = '0;
    end

    // One-cycle write pulse, so back-to-back calls never overlap
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWr <= '{valid: 1'h1, addr: a, data: d};
        @(posedge mclk);
        regWr <= '0;
    endtask : wr

    // Level held until the caller drops it; wake wait is the caller's job
    task automatic trig(input logic lvl);
        @(posedge mclk);
        convTrig <= lvl;
    endtask : trig

    task automatic pdown(input logic unlock, input logic [7:0] d);
        if (unlock) begin
            wr(alpm_pkg::UNLOCK_ADDR, alpm_pkg::UNLOCK_KEY);
        end
        wr(alpm_pkg::PWR_CTRL_ADDR, d);
        @(posedge mclk);
        chipSelN <= 1'h0;
        repeat (4) @(posedge mclk);
        chipSelN <= 1'h1;
    endtask : pdown
endmodule : alpm_host

// *** verif/test_adc_low_power_mode_control.sv ***
// Testbench for the converter power-mode controller: reset, conversion, nap, powerdown.
// Assumes the host model alpm_host; powerup count shortened to keep the run brief.
module test_adc_low_power_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PWRUP = 10;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic convTrig, chipSelN, readyInd, pdMode, napMode, convBusy;
    alpm_pkg::alpm_wr_t regWr;
    alpm_pkg::alpm_pwr_t pwrEn;
    logic [7:0] ctrlReg;
    int bad_count = 0;
    int check_count = 0;

    always #2.5 mclk = ~mclk;

    alpm_host host (.mclk(mclk), .convTrig(convTrig), .chipSelN(chipSelN), .regWr(regWr));
    alpm_ctrl #(.PWRUP_CYCLES(PWRUP)) dut (.mclk(mclk), .rst(rst), .convTrigPin(convTrig),
        .chipSelNPin(chipSelN), .regWr(regWr), .readyInd(readyInd), .deepPowerdownMode(pdMode),
        .napMode(napMode), .convBusy(convBusy), .pwrEn(pwrEn), .powerControlReg(ctrlReg));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    task automatic scn_reset();
        cyc(2);
        chk(readyInd, 1'h1, "ready after reset");
        chk(pwrEn, 3'h7, "all on in normal");
        chk(ctrlReg, alpm_pkg::PWR_CTRL_RST, "control reset value");
        chk({pdMode, napMode, convBusy}, 3'h0, "idle modes");
    endtask : scn_reset

    // Trigger held high across conversion end, so nap only if enabled
    task automatic scn_conv(input logic napOn);
        int n;
        n = 0;
        host.trig(1'h1);
        while (convBusy !== 1'h1 && n < 10) begin
            n++;
            cyc(1);
        end
        chk(pwrEn, 3'h7, "all on while converting");
        n = 0;
        while (convBusy === 1'h1 && n < 100) begin
            n++;
            cyc(1);
        end
        chk(n[7:0], 8'(alpm_pkg::CONV_CYC), "conversion length");
        cyc(2);
        chk(napMode, napOn, "nap at conversion end");
        chk(pwrEn.acqBlocksOn, !napOn, "acquisition blocks in nap");
        cyc(20);
        chk(napMode, napOn, "nap held with trigger high");
        host.trig(1'h0);
        cyc(6);
        chk(napMode, 1'h0, "trigger fall wakes");
        cyc(alpm_pkg::NAP_WAKE_CYC + 4);
    endtask : scn_conv

    task automatic scn_pd();
        host.pdown(1'h0, 8'h03);
        cyc(8);
        chk(ctrlReg, 8'h02, "locked request ignored");
        chk(pdMode, 1'h0, "no powerdown while locked");
        host.pdown(1'h1, 8'h01);
        cyc(8);
        chk(pdMode, 1'h1, "powerdown on chip-select rise");
        chk(pwrEn, 3'h0, "analog off");
        chk(readyInd, 1'h0, "not ready in powerdown");
        host.wr(alpm_pkg::PWR_CTRL_ADDR, 8'h03);
        cyc(1);
        chk(ctrlReg, 8'h03, "writes work in powerdown");
        chk(pdMode, 1'h1, "still powered down");
        host.trig(1'h1);
        cyc(10);
        chk(convBusy, 1'h0, "no conversion in powerdown");
        host.trig(1'h0);
        cyc(4);
        host.wr(alpm_pkg::PWR_CTRL_ADDR, 8'h00);
        cyc(1);
        chk(pdMode, 1'h0, "exit on clear");
        chk(readyInd, 1'h0, "ready one cycle later");
        cyc(1);
        chk(readyInd, 1'h1, "ready rises at exit");
        chk(pwrEn, 3'h7, "analog back on");
        cyc(PWRUP + 2);
        scn_conv(1'h0);
    endtask : scn_pd

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        scn_reset();
        scn_conv(1'h0);
        host.wr(alpm_pkg::PWR_CTRL_ADDR, 8'h02);
        cyc(1);
        chk(ctrlReg, 8'h02, "nap enable written");
        scn_conv(1'h1);
        scn_pd();
        end_sim();
    end

    // Whole run is well under 1000 cycles
    initial begin
        #20000;
        bad_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule : test_adc_low_power_mode_control
